/* config_loader_defines.vh */
// Purpose: constants for the configuration image loader
// Assumes: 100 MHz system clock, byte addressed serial memory with 16-bit addresses
// Notes: byte offsets are image byte addresses
// Contract
// RULE1: memory addressed with control byte a0h to write, a1h to read
// RULE2: each stored word keeps its high byte at the lower address
// RULE3: after every reset the signature word is read before any setting is used
// RULE4: signature sits at byte 510 and must read 4432h
// RULE5: signature present loads the whole image, absent skips loading
// RULE6: a stored slave address word other than 00ffh replaces the strap address
// RULE7: image is 16-bit words, per-channel settings in four words, page 0 first
// RULE8: fault cause 0, mode 2, targets 24-30, rise 32, delay 40, fall 64
// RULE9: image writer keeps mode word equal to the timebase reload word
// RULE10: temperature reads subtract 3010, stores add 3010
// RULE11: voltage unchanged in 2V range, times or over 2.75 in 5.5V range
// RULE12: conversions happen in the loader on every save and read out; loaded words are stored raw and converted at host read out
// RULE13: channel 2 target at bytes 28 and 29, high byte first
// RULE14: image writers should save a working device and edit few fields
// RULE15: settings released only after all reads and the signature check
`ifndef CONFIG_LOADER_DEFINES_VH
`define CONFIG_LOADER_DEFINES_VH
// ----------------------------------------
// bus timing
// ----------------------------------------
`define SYS_CLK_KHZ 100000
`define SCL_MAX_KHZ 400
`define SCL_QTR_CYC ((`SYS_CLK_KHZ + 4 * `SCL_MAX_KHZ - 1) / (4 * `SCL_MAX_KHZ))
`define EE_WRITE_MS 5
`define EE_WRITE_CYC (`SYS_CLK_KHZ * `EE_WRITE_MS)
// ----------------------------------------
// control bytes and image layout
// ----------------------------------------
`define CTRL_WR 8'ha0
`define CTRL_RD 8'ha1
`define OFS_SIGNATURE 16'h01fe
`define SIGNATURE_VAL 16'h4432
`define IMAGE_BYTES 9'h1fe
`define OFS_FAULT_CAUSE 9'h000
`define OFS_MODE 9'h002
`define OFS_VOUT_TARGET 9'h018
`define OFS_TON_RISE 9'h020
`define OFS_TON_DELAY 9'h028
`define OFS_TOFF_FALL 9'h040
`define OFS_SET_ADDR 9'h08c
`define ADDR_KEEP 16'h00ff
`define TEMP_OFFSET 16'h0bc2
`endif

/* config_eeprom_boot_loader.v */
// Purpose: boot loader and saver of configuration words in a serial memory
// Assumes: open-drain pins resolved outside, host port on sys_clk
// Notes: read port converts to host form, writes convert and save one word
`timescale 1ns/1ps
`include "config_loader_defines.vh"
module config_eeprom_boot_loader #(
  parameter WRITE_WAIT_CYC = `EE_WRITE_CYC,
  parameter QTR_CYC = `SCL_QTR_CYC,
  parameter [6:0] STRAP_BASE = 7'h50
) (
  input wire sys_clk,
  input wire rst_b,
  input wire eeprom_data_pin_in,
  output reg eeprom_data_pin_out,
  output reg eeprom_data_pin_oe,
  output reg eeprom_clock_pin_out,
  output reg eeprom_clock_pin_oe,
  input wire [2:0] address_strap_pins,
  input wire range_5v5,
  input wire [7:0] host_index,
  input wire host_wr,
  input wire [15:0] host_wdata,
  output reg [15:0] host_rdata,
  output reg cfg_valid,
  output reg image_found,
  output reg loader_busy,
  output reg link_error,
  output reg [6:0] slave_address
);
  localparam B_IDLE = 3'd0;
  localparam B_START = 3'd1;
  localparam B_TX = 3'd2;
  localparam B_RX = 3'd3;
  localparam B_STOP = 3'd4;
  localparam SQ_SIG = 3'd0;
  localparam SQ_LOAD = 3'd1;
  localparam SQ_READY = 3'd2;
  localparam SQ_SAVE = 3'd3;
  localparam SQ_WAIT = 3'd4;
  localparam [7:0] QTR = QTR_CYC[7:0];

  reg [15:0] mem [0:255];
  reg sda_s1, sda_s2;
  reg [2:0] strap_s1, strap_s2;
  reg [7:0] tcnt;
  reg tick;
  reg [2:0] bs, seq;
  reg [1:0] q;
  reg [3:0] bitn;
  reg [2:0] bi;
  reg rdp, nak, eng_done, go, wr;
  reg [7:0] sh, hi;
  reg [8:0] bc, len;
  reg [15:0] addr, wdat, sigw, addrw;
  reg word_we;
  reg [15:0] word_val;
  reg [7:0] word_idx;
  reg [19:0] wcnt;
  wire last = (bc == len - 9'd1);

  // ----------------------------------------
  // conversions
  // ----------------------------------------
  function is_temp;
    input [7:0] i;
    begin
      is_temp = (i == 8'd2) || (i == 8'd3) || (i == 8'd36) || (i == 8'd68);
    end
  endfunction
  // RULE8 voltage word spans
  function is_volt;
    input [7:0] i;
    begin
      is_volt = (i >= 8'd4 && i <= 8'd15) ||
                (i >= 8'd24 && i <= 8'd31) || (i >= 8'd149 && i <= 8'd164);
    end
  endfunction
  function [15:0] to_host;
    input [7:0] i;
    input [15:0] v;
    input r;
    reg [17:0] p;
    begin
      p = {2'b00, v} * 18'd11;
      to_host = v;
      // RULE10 read subtracts offset
      if (is_temp(i))
        to_host = v - `TEMP_OFFSET;
      // RULE11 read times 2.75
      else if (is_volt(i) && r)
        to_host = p[17:2];
    end
  endfunction
  function [15:0] to_int;
    input [7:0] i;
    input [15:0] v;
    input r;
    reg [17:0] p;
    begin
      p = {v, 2'b00} / 18'd11;
      to_int = v;
      // RULE10 store adds offset
      if (is_temp(i))
        to_int = v + `TEMP_OFFSET;
      // RULE11 store over 2.75
      else if (is_volt(i) && r)
        to_int = p[15:0];
    end
  endfunction

  // ----------------------------------------
  // pin sync and bit timing
  // ----------------------------------------
  // two stages before any use, pins are asynchronous
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      strap_s1 <= 3'h0;
      strap_s2 <= 3'h0;
      tcnt <= 8'h00;
      tick <= 1'b0;
    end else begin
      sda_s1 <= eeprom_data_pin_in;
      sda_s2 <= sda_s1;
      strap_s1 <= address_strap_pins;
      strap_s2 <= strap_s1;
      tick <= (tcnt == QTR - 8'd1);
      tcnt <= (tcnt == QTR - 8'd1) ? 8'h00 : tcnt + 8'd1;
    end
  end

  // ----------------------------------------
  // byte engine, four quarters per bit
  // ----------------------------------------
  // no clock stretching: memory parts of this kind never hold the clock
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bs <= B_IDLE;
      q <= 2'd0;
      bitn <= 4'd0;
      bi <= 3'd0;
      rdp <= 1'b0;
      nak <= 1'b0;
      sh <= 8'h00;
      hi <= 8'h00;
      bc <= 9'h000;
      eng_done <= 1'b0;
      word_we <= 1'b0;
      word_val <= 16'h0000;
      word_idx <= 8'h00;
      eeprom_clock_pin_oe <= 1'b0;
      eeprom_data_pin_oe <= 1'b0;
      eeprom_clock_pin_out <= 1'b0;
      eeprom_data_pin_out <= 1'b0;
    end else begin
      eng_done <= 1'b0;
      word_we <= 1'b0;
      eeprom_clock_pin_out <= 1'b0;
      eeprom_data_pin_out <= 1'b0;
      if (tick) begin
        q <= q + 2'd1;
        case (bs)
          B_IDLE: begin
            q <= 2'd0;
            if (go) begin
              bs <= B_START;
              bi <= 3'd0;
              rdp <= 1'b0;
              bc <= 9'h000;
              nak <= 1'b0;
            end
          end
          // start and repeated start share one shape
          B_START: begin
            case (q)
              2'd0: begin
                eeprom_data_pin_oe <= 1'b0;
                eeprom_clock_pin_oe <= 1'b1;
              end
              2'd1: eeprom_clock_pin_oe <= 1'b0;
              2'd2: eeprom_data_pin_oe <= 1'b1;
              default: begin
                eeprom_clock_pin_oe <= 1'b1;
                bs <= B_TX;
                bitn <= 4'd0;
                // RULE1 control bytes
                sh <= rdp ? `CTRL_RD : `CTRL_WR;
              end
            endcase
          end
          B_TX: begin
            case (q)
              2'd0: begin
                eeprom_clock_pin_oe <= 1'b1;
                eeprom_data_pin_oe <= (bitn == 4'd8) ? 1'b0 : ~sh[7];
              end
              2'd1: eeprom_clock_pin_oe <= 1'b0;
              2'd2: if (bitn == 4'd8) nak <= sda_s2;
              default: begin
                eeprom_clock_pin_oe <= 1'b1;
                bitn <= bitn + 4'd1;
                sh <= {sh[6:0], 1'b0};
                if (bitn == 4'd8) begin
                  bitn <= 4'd0;
                  bi <= bi + 3'd1;
                  // a refused byte ends the transfer at once
                  if (nak)
                    bs <= B_STOP;
                  else if (rdp)
                    bs <= B_RX;
                  else if (bi == 3'd0)
                    sh <= addr[15:8];
                  else if (bi == 3'd1)
                    sh <= addr[7:0];
                  else if (bi == 3'd2 && !wr) begin
                    rdp <= 1'b1;
                    bs <= B_START;
                  // RULE2 high byte first on save
                  end else if (bi == 3'd2)
                    sh <= wdat[15:8];
                  else if (bi == 3'd3)
                    sh <= wdat[7:0];
                  else
                    bs <= B_STOP;
                end
              end
            endcase
          end
          B_RX: begin
            case (q)
              2'd0: begin
                eeprom_clock_pin_oe <= 1'b1;
                eeprom_data_pin_oe <= (bitn == 4'd8) ? ~last : 1'b0;
              end
              2'd1: eeprom_clock_pin_oe <= 1'b0;
              2'd2: if (bitn != 4'd8) sh <= {sh[6:0], sda_s2};
              default: begin
                eeprom_clock_pin_oe <= 1'b1;
                bitn <= bitn + 4'd1;
                if (bitn == 4'd8) begin
                  bitn <= 4'd0;
                  bc <= bc + 9'd1;
                  // RULE2 even byte is the high half
                  if (!bc[0])
                    hi <= sh;
                  else begin
                    word_we <= 1'b1;
                    word_val <= {hi, sh};
                    // RULE7 word index from byte count of the transfer, load starts at byte 0
                    word_idx <= bc[8:1];
                  end
                  if (last) bs <= B_STOP;
                end
              end
            endcase
          end
          B_STOP: begin
            case (q)
              2'd0: begin
                eeprom_clock_pin_oe <= 1'b1;
                eeprom_data_pin_oe <= 1'b1;
              end
              2'd1: eeprom_clock_pin_oe <= 1'b0;
              2'd2: eeprom_data_pin_oe <= 1'b0;
              default: begin
                bs <= B_IDLE;
                eng_done <= 1'b1;
              end
            endcase
          end
          default: bs <= B_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // boot and save sequencer
  // ----------------------------------------
  // RULE3 probe signature first
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      seq <= SQ_SIG;
      go <= 1'b1;
      wr <= 1'b0;
      addr <= `OFS_SIGNATURE;
      len <= 9'd2;
      wdat <= 16'h0000;
      sigw <= 16'h0000;
      addrw <= `ADDR_KEEP;
      wcnt <= 20'h00000;
      cfg_valid <= 1'b0;
      image_found <= 1'b0;
      loader_busy <= 1'b1;
      link_error <= 1'b0;
      slave_address <= 7'h00;
    end else begin
      if (bs != B_IDLE) go <= 1'b0;
      loader_busy <= (seq != SQ_READY);
      if (eng_done && nak) link_error <= 1'b1;
      if (word_we && seq == SQ_SIG) sigw <= word_val;
      if (word_we && seq == SQ_LOAD && {word_idx, 1'b0} == `OFS_SET_ADDR) addrw <= word_val;
      case (seq)
        SQ_SIG: if (eng_done) begin
          // RULE4 signature compare
          if (!nak && sigw == `SIGNATURE_VAL) begin
            // RULE5 load whole image
            seq <= SQ_LOAD;
            addr <= 16'h0000;
            len <= `IMAGE_BYTES;
            go <= 1'b1;
          end else begin
            // RULE5 absent image skips load
            seq <= SQ_READY;
            cfg_valid <= 1'b1;
            slave_address <= STRAP_BASE | {4'h0, strap_s2};
          end
        end
        SQ_LOAD: if (eng_done) begin
          // RULE15 release after last read
          seq <= SQ_READY;
          cfg_valid <= 1'b1;
          image_found <= !nak;
          // RULE6 stored address overrides straps
          if (!nak && addrw != `ADDR_KEEP)
            slave_address <= addrw[6:0];
          else
            slave_address <= STRAP_BASE | {4'h0, strap_s2};
        end
        SQ_READY: if (host_wr) begin
          seq <= SQ_SAVE;
          wr <= 1'b1;
          // RULE13 byte address is twice the index
          addr <= {7'h00, host_index, 1'b0};
          // RULE12 convert on save
          wdat <= to_int(host_index, host_wdata, range_5v5);
          len <= 9'd2;
          go <= 1'b1;
        end
        SQ_SAVE: if (eng_done) begin
          seq <= SQ_WAIT;
          wcnt <= 20'h00000;
        end
        SQ_WAIT: begin
          // memory ignores the bus during its internal write
          wcnt <= wcnt + 20'd1;
          if (wcnt == WRITE_WAIT_CYC[19:0] - 20'd1) begin
            seq <= SQ_READY;
            wr <= 1'b0;
          end
        end
        default: seq <= SQ_READY;
      endcase
    end
  end

  // ----------------------------------------
  // settings store and host read port
  // ----------------------------------------
  // store holds internal form; host sees converted form
  always @(posedge sys_clk) begin
    if (word_we && seq == SQ_LOAD)
      mem[word_idx] <= word_val;
    else if (host_wr && seq == SQ_READY)
      mem[host_index] <= to_int(host_index, host_wdata, range_5v5);
  end

  // RULE12 convert on read out
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      host_rdata <= 16'h0000;
    else if (cfg_valid)
      host_rdata <= to_host(host_index, mem[host_index], range_5v5);
    else
      host_rdata <= 16'h0000;
  end
endmodule // config_eeprom_boot_loader

/* loader_props.sv */
// Purpose: port checks for the boot loader
// Assumes: strap pins held still while the loader runs
// Notes: bound to every loader instance
`timescale 1ns/1ps
module loader_props #(
  parameter [6:0] STRAP_BASE = 7'h50
) (
  input wire sys_clk,
  input wire rst_b,
  input wire eeprom_data_pin_out,
  input wire eeprom_data_pin_oe,
  input wire eeprom_clock_pin_out,
  input wire eeprom_clock_pin_oe,
  input wire [2:0] address_strap_pins,
  input wire host_wr,
  input wire [15:0] host_rdata,
  input wire cfg_valid,
  input wire image_found,
  input wire loader_busy,
  input wire link_error,
  input wire [6:0] slave_address
);
  // ----------------------------------------
  // link pin checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  property p_data_hold;
    $changed(eeprom_data_pin_oe) |=> $stable(eeprom_data_pin_oe) [*3];
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data pin changed too soon");
  property p_clk_hold;
    $changed(eeprom_clock_pin_oe) |=> $stable(eeprom_clock_pin_oe) [*3];
  endproperty
  a_clk_hold: assert property (p_clk_hold) else $error("clock pin changed too soon");
  property p_open_drain;
    !eeprom_data_pin_out && !eeprom_clock_pin_out;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("pin driven high");
  property p_idle_free;
    !loader_busy |-> !eeprom_data_pin_oe && !eeprom_clock_pin_oe;
  endproperty
  a_idle_free: assert property (p_idle_free) else $error("bus held while idle");
  // ----------------------------------------
  // boot and host checks
  // ----------------------------------------
  property p_quiet_rdata;
    !cfg_valid |-> host_rdata == 16'h0000;
  endproperty
  a_quiet_rdata: assert property (p_quiet_rdata) else $error("data shown before boot");
  property p_found_valid;
    image_found |-> cfg_valid;
  endproperty
  a_found_valid: assert property (p_found_valid) else $error("image flag early");
  property p_valid_hold;
    cfg_valid |=> cfg_valid;
  endproperty
  a_valid_hold: assert property (p_valid_hold) else $error("boot flag dropped");
  property p_save_busy;
    host_wr && !loader_busy |-> ##2 loader_busy;
  endproperty
  a_save_busy: assert property (p_save_busy) else $error("save not launched");
  property p_strap_addr;
    cfg_valid && !image_found |-> slave_address == (STRAP_BASE | {4'h0, address_strap_pins});
  endproperty
  a_strap_addr: assert property (p_strap_addr) else $error("strap address wrong");
  property p_error_hold;
    link_error |=> link_error;
  endproperty
  a_error_hold: assert property (p_error_hold) else $error("link error cleared");
endmodule // loader_props
bind config_eeprom_boot_loader loader_props #(.STRAP_BASE(STRAP_BASE)) i_props (
  .sys_clk(sys_clk),
  .rst_b(rst_b),
  .eeprom_data_pin_out(eeprom_data_pin_out),
  .eeprom_data_pin_oe(eeprom_data_pin_oe),
  .eeprom_clock_pin_out(eeprom_clock_pin_out),
  .eeprom_clock_pin_oe(eeprom_clock_pin_oe),
  .address_strap_pins(address_strap_pins),
  .host_wr(host_wr),
  .host_rdata(host_rdata),
  .cfg_valid(cfg_valid),
  .image_found(image_found),
  .loader_busy(loader_busy),
  .link_error(link_error),
  .slave_address(slave_address)
);

/* eeprom_model.sv */
// Purpose: behavioural serial memory on the loader link
// Assumes: two address bytes, pulled-up data wire
// Notes: nack_all refuses every byte
`timescale 1ns/1ps
module eeprom_model (
  input wire scl,
  input wire sda,
  input wire nack_all,
  output reg sda_oe
);
  reg [7:0] mem [0:511];
  reg [7:0] sh;
  reg [15:0] ptr;
  reg [15:0] rd_addr;
  reg act, rd, rdg, mack, bad_ctrl;
  integer bn, bc, k;
  // empty memory, wire released
  initial begin
    {sda_oe, act, rd, rdg, mack, bad_ctrl, sh, ptr, rd_addr} = 0;
    bn = 0;
    bc = 0;
    for (k = 0; k < 512; k = k + 1) mem[k] = 8'h00;
  end
  // start or repeated start opens a frame
  always @(negedge sda) if (scl === 1'b1) begin
    {act, rd, rdg} = 3'b100;
    // the clock fall that follows the start carries no bit
    bn = -1;
    bc = 0;
  end
  // stop closes it
  always @(posedge sda) if (scl === 1'b1) act = 0;
  // sample while the clock is high
  always @(posedge scl) if (act) begin
    if (bn < 8) sh = {sh[6:0], sda};
    else mack = !sda;
  end
  always @(negedge scl) if (act) begin
    sda_oe = 0;
    if (bn == 7 && !rd) begin
      bn = 8;
      if (bc == 0) begin
        rd = sh[0];
        bad_ctrl = bad_ctrl | (sh[7:1] != 7'h50);
        if (sh[0]) rd_addr = ptr;
      end else if (bc == 1) ptr[15:8] = sh;
      else if (bc == 2) ptr[7:0] = sh;
      else begin
        mem[ptr[8:0]] = sh;
        ptr = ptr + 1;
      end
      bc = bc + 1;
      sda_oe = !nack_all;
    end else if (bn == 8) begin
      bn = 0;
      if (rdg) ptr = ptr + 1;
      if (rdg && !mack) begin
        act = 0;
        rdg = 0;
      end
      if (rd && act) rdg = 1;
      if (rdg) sda_oe = !mem[ptr[8:0]][7];
    end else begin
      bn = bn + 1;
      if (rdg && bn < 8) sda_oe = !mem[ptr[8:0]][7 - bn];
    end
  end
endmodule // eeprom_model

/* config_eeprom_boot_loader_tb_top.sv */
// Purpose: self-checking bench for the boot loader
// Assumes: short write wait, memory model on the link pins
// Notes: short quarter tick, one full image load costs about 75k cycles
`timescale 1ns/1ps
module config_eeprom_boot_loader_tb_top;
  reg sys_clk, rst_b, range_5v5, host_wr, nack_all;
  reg [2:0] address_strap_pins;
  reg [7:0] host_index;
  reg [15:0] host_wdata;
  wire [15:0] host_rdata;
  wire [6:0] slave_address;
  wire sda_out, sda_oe, scl_out, scl_oe, mem_oe, cfg_valid, image_found, loader_busy, link_error;
  // open-drain wires with pull-ups
  wire sda = !(sda_oe | mem_oe);
  wire scl = !scl_oe;
  integer fail_count, n_tests, t;
  config_eeprom_boot_loader #(.WRITE_WAIT_CYC(200), .QTR_CYC(4)) i_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .eeprom_data_pin_in(sda),
    .eeprom_data_pin_out(sda_out), .eeprom_data_pin_oe(sda_oe),
    .eeprom_clock_pin_out(scl_out), .eeprom_clock_pin_oe(scl_oe),
    .address_strap_pins(address_strap_pins), .range_5v5(range_5v5),
    .host_index(host_index), .host_wr(host_wr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .cfg_valid(cfg_valid), .image_found(image_found),
    .loader_busy(loader_busy), .link_error(link_error), .slave_address(slave_address));
  eeprom_model i_mem (.scl(scl), .sda(sda), .nack_all(nack_all), .sda_oe(mem_oe));
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task check16(input string name, input [15:0] exp, input [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // bounded wait: a hang counts as a mismatch
  task wait_for(input string name, input integer lim, input bit want_valid);
    t = 0;
    while ((want_valid ? cfg_valid !== 1'b1 : loader_busy !== 1'b0) && t < lim) begin
      @(negedge sys_clk);
      t++;
    end
    if (t >= lim) begin
      check16(name, 16'h0001, 16'h0000);
      tally_and_finish;
    end
  endtask
  task boot;
    rst_b = 0;
    repeat (10) @(negedge sys_clk);
    rst_b = 1;
    wait_for("boot", 90000, 1);
  endtask
  task put(input [7:0] idx, input [15:0] v);
    @(negedge sys_clk);
    {host_index, host_wdata, host_wr} = {idx, v, 1'b1};
    @(negedge sys_clk);
    host_wr = 0;
    repeat (4) @(negedge sys_clk);
    wait_for("save", 40000, 0);
  endtask
  task get(input [7:0] idx, input string name, input [15:0] exp);
    @(negedge sys_clk);
    host_index = idx;
    @(negedge sys_clk);
    check16(name, exp, host_rdata);
  endtask
  function [15:0] word(input integer a);
    word = {i_mem.mem[a], i_mem.mem[a + 1]};
  endfunction
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_blank;
    boot;
    check16("found", 16'h0000, {15'h0, image_found});
    check16("sig addr", 16'h01fe, i_mem.rd_addr);
    check16("strap addr", 16'h0055, {9'h0, slave_address});
    check16("no link err", 16'h0000, {15'h0, link_error});
  endtask
  task t_save;
    range_5v5 = 0;
    put(14, 16'd5998);
    check16("ch2 store", 16'h176e, word(28));
    range_5v5 = 1;
    put(12, 16'd5998);
    check16("5v5 store", 16'h0885, word(24));
    put(2, 16'd100);
    check16("temp store", 16'h0c26, word(4));
    get(2, "temp read", 16'd100);
    check16("ctrl byte", 16'h0000, {15'h0, i_mem.bad_ctrl});
  endtask
  task t_full;
    // working image with few hand edits, mode word equal to reload word
    {i_mem.mem[0], i_mem.mem[1], i_mem.mem[2], i_mem.mem[3]} = 32'h1234_0007;
    {i_mem.mem[206], i_mem.mem[207]} = 16'h0007;
    {i_mem.mem[140], i_mem.mem[141], i_mem.mem[510], i_mem.mem[511]} = 32'h0023_4432;
    boot;
    check16("found", 16'h0001, {15'h0, image_found});
    check16("load addr", 16'h0023, {9'h0, slave_address});
    get(0, "fault cause", 16'h1234);
    get(1, "mode", 16'h0007);
    get(2, "temp load", 16'd100);
    get(12, "5v5 load", 16'd5997);
    range_5v5 = 0;
    get(14, "ch2 load", 16'd5998);
  endtask
  task t_nack;
    nack_all = 1;
    boot;
    check16("link err", 16'h0001, {15'h0, link_error});
    check16("nack found", 16'h0000, {15'h0, image_found});
    nack_all = 0;
  endtask
  // main sequence
  initial begin
    {rst_b, range_5v5, host_wr, nack_all, host_index, host_wdata} = 0;
    address_strap_pins = 3'h5;
    fail_count = 0;
    n_tests = 0;
    t_blank;
    t_save;
    t_full;
    t_nack;
    tally_and_finish;
  end
endmodule // config_eeprom_boot_loader_tb_top
